// [verilog/nfcpg_top.sv]
// paged tuning register bank with the command sequencer of the reader
// assumes the host port and FIFO datapath run on CLK; analog readings are asynchronous
`timescale 1ns/100ps
`include "nfcpg_cfg.svh"
module nfcpg_top
  import nfcpg_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // host register port
  input wire logic [5:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // FIFO and datapath handshakes
  input wire logic FIFO_EMPTY,
  input wire logic TX_DONE,
  input wire logic RX_DONE,
  input wire logic AUTH_DONE,
  output logic PARAM_POP,
  output logic CMD_ABORT,
  output logic TX_EN,
  output logic RX_EN,
  output logic CRC_EN,
  output logic AUTH_EN,
  // analog readings
  input wire logic [7:0] DETECT_REF,
  input wire logic [7:0] DETECT_VAL,
  input wire logic [2:0] TEMP_OVER,
  // tuning outputs
  output nfcpg_tune_t TUNE
);

  nfcpg_state_t st_r;
  nfcpg_state_t st_nxt;
  logic wr_p4;
  logic wr_p5;
  logic wr_p6;
  logic [7:0] rd_mux;
  logic [7:0] base_s;
  logic [7:0] lo_s;
  logic [7:0] hi_s;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction : merge

  // ****************************************
  // reset image
  // ****************************************
  // elaboration-time constant, so the asynchronous reset branch loads no logic-driven value
  function automatic nfcpg_state_t reset_image();
    nfcpg_state_t v;
    v = '0;
    v.special = `NFCPG_R_SPECIAL;
    v.analog = `NFCPG_R_ANALOG;
    v.noise = `NFCPG_R_NOISE;
    v.step = `NFCPG_R_STEP;
    v.page5_gain_threshold_a = `NFCPG_R_PAGE5_GAIN_THRESHOLD_A;
    v.alg6 = `NFCPG_R_ALG6;
    v.alg7 = `NFCPG_R_ALG7;
    v.alg8 = `NFCPG_R_ALG8;
    v.alg9 = `NFCPG_R_ALG9;
    v.cal = `NFCPG_R_CAL;
    v.rc27 = `NFCPG_R_RC27;
    v.rc32 = `NFCPG_R_RC32;
    v.adcref = `NFCPG_R_ADCREF;
    v.cwgsn = `NFCPG_R_CWGSN;
    v.cwgsp = `NFCPG_R_CWGSP;
    v.cmd_state = CS_IDLE;
    v.tune.rx_wait_unit = `NFCPG_UNIT_SLOW;
    v.tune.tx_wait_unit = `NFCPG_UNIT_SLOW;
    reset_image = v;
  endfunction : reset_image
  localparam nfcpg_state_t rst_val = reset_image();

  // ****************************************
  // page decode
  // ****************************************
  // paged writes only land while the selector holds the matching unlock value
  // page four, five and six gates
  assign wr_p4 = REG_WR && (st_r.page == `NFCPG_UNLOCK_P4);
  assign wr_p5 = REG_WR && (st_r.page == `NFCPG_UNLOCK_P5);
  assign wr_p6 = REG_WR && (st_r.page == `NFCPG_UNLOCK_P6);

  always_comb
  begin
    rd_mux = 8'h00;
    if (REG_ADDR == `NFCPG_A_PRIVATE_PAGE_SELECTOR)
      rd_mux = st_r.page;
    else if (REG_ADDR == `NFCPG_A_COMMAND)
      rd_mux = {4'h0, st_r.cmd_code};
    else if (REG_ADDR == `NFCPG_A_FRAMING)
      rd_mux = {st_r.launch, 7'h00};
    else if (st_r.page == `NFCPG_UNLOCK_P4)
    begin
      if (REG_ADDR == `NFCPG_A_SPECIAL)
        rd_mux = st_r.special;
    end
    else if (st_r.page == `NFCPG_UNLOCK_P5)
    begin
      unique case (REG_ADDR)
        `NFCPG_A_ANALOG: rd_mux = st_r.analog;
        `NFCPG_A_NOISE: rd_mux = st_r.noise;
        `NFCPG_A_STEP: rd_mux = st_r.step;
        `NFCPG_A_PAGE5_GAIN_THRESHOLD_A: rd_mux = st_r.page5_gain_threshold_a;
        `NFCPG_A_ALG6: rd_mux = st_r.alg6;
        `NFCPG_A_ALG7: rd_mux = st_r.alg7;
        `NFCPG_A_ALG8: rd_mux = st_r.alg8;
        `NFCPG_A_ALG9: rd_mux = st_r.alg9;
        default: rd_mux = 8'h00;
      endcase
    end
    else if (st_r.page == `NFCPG_UNLOCK_P6)
    begin
      unique case (REG_ADDR)
        `NFCPG_A_DREF: rd_mux = st_r.ref_s2;
        `NFCPG_A_DDET: rd_mux = st_r.det_s2;
        `NFCPG_A_CAL: rd_mux = st_r.cal;
        `NFCPG_A_RC27: rd_mux = st_r.rc27;
        `NFCPG_A_RC32: rd_mux = st_r.rc32;
        `NFCPG_A_ADCREF: rd_mux = st_r.adcref;
        `NFCPG_A_CWGSN: rd_mux = st_r.cwgsn;
        `NFCPG_A_CWGSP: rd_mux = st_r.cwgsp;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // ****************************************
  // conductance search window
  // ****************************************
  // unsigned 8-bit arithmetic: low end floors at 0, high end clamps to the 6-bit field
  assign base_s = {2'b00, st_r.cwgsp[5:0]};
  always_comb
  begin
    lo_s = base_s;
    hi_s = base_s;
    if (st_r.cal[`NFCPG_B_CAL_METHOD])
    begin
      unique case (st_r.cal[7:6])
        2'h0:
        begin
          lo_s = (base_s < 8'h08) ? 8'h00 : base_s - 8'h08;
          hi_s = base_s + 8'h07;
        end
        2'h1:
        begin
          lo_s = (base_s < 8'h10) ? 8'h00 : base_s - 8'h10;
          hi_s = base_s + 8'h0E;
        end
        2'h2:
        begin
          lo_s = (base_s < 8'h18) ? 8'h00 : base_s - 8'h18;
          hi_s = base_s + 8'h15;
        end
        2'h3:
        begin
          lo_s = 8'h02;
          hi_s = 8'h3E;
        end
      endcase
    end
    if (hi_s > 8'h3F)
      hi_s = 8'h3F;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.abort = 1'b0;
    st_nxt.rdata = REG_RD ? rd_mux : st_r.rdata;
    st_nxt.ref_s1 = DETECT_REF;
    st_nxt.ref_s2 = st_r.ref_s1;
    st_nxt.det_s1 = DETECT_VAL;
    st_nxt.det_s2 = st_r.det_s1;
    st_nxt.hot_s1 = TEMP_OVER;
    st_nxt.hot_s2 = st_r.hot_s1;

    st_nxt.tune.rx_wait_unit = st_r.special[`NFCPG_B_RXUNIT] ? `NFCPG_UNIT_FAST : `NFCPG_UNIT_SLOW;
    st_nxt.tune.tx_wait_unit = st_r.special[`NFCPG_B_TXUNIT] ? `NFCPG_UNIT_FAST : `NFCPG_UNIT_SLOW;
    // undefined code falls back to auto
    unique case (st_r.special[5:4])
      2'h1: st_nxt.tune.demod_algorithm_select = DEMOD_ALG1;
      2'h2: st_nxt.tune.demod_algorithm_select = DEMOD_ALG2;
      default: st_nxt.tune.demod_algorithm_select = DEMOD_AUTO;
    endcase
    st_nxt.tune.per_character_resync = st_r.noise[`NFCPG_B_RESYNC];
    st_nxt.tune.top_rate_filter_bypass = st_r.alg6[`NFCPG_B_FLT_BYP];
    st_nxt.tune.subcarrier_end_check_off = st_r.alg6[`NFCPG_B_SUBEND_OFF];
    // threshold pick; code 00 never trips
    unique case (st_r.analog[4:3])
      2'h1: st_nxt.tune.tx_inhibit_hot = !st_r.analog[`NFCPG_B_TEMP_OFF] && st_r.hot_s2[0];
      2'h2: st_nxt.tune.tx_inhibit_hot = !st_r.analog[`NFCPG_B_TEMP_OFF] && st_r.hot_s2[1];
      2'h3: st_nxt.tune.tx_inhibit_hot = !st_r.analog[`NFCPG_B_TEMP_OFF] && st_r.hot_s2[2];
      default: st_nxt.tune.tx_inhibit_hot = 1'b0;
    endcase
    st_nxt.tune.search_lo = lo_s[5:0];
    st_nxt.tune.search_hi = hi_s[5:0];

    // sequencer progress
    unique case (st_r.cmd_state)
      CS_IDLE:
        st_nxt.cmd_code = `NFCPG_CMD_IDLE;
      CS_PARAMS:
      begin
        if (!FIFO_EMPTY)
          st_nxt.param_cnt = st_r.param_cnt + 4'h1;
        if (!FIFO_EMPTY && st_r.param_cnt == `NFCPG_AUTH_PARAMS - 4'h1)
          st_nxt.cmd_state = CS_AUTH;
      end
      CS_STREAM:
        st_nxt.cmd_state = CS_STREAM;
      CS_TX:
        if (TX_DONE)
          st_nxt.cmd_state = CS_IDLE;
      CS_LAUNCH_WAIT:
      begin
        if (st_r.launch)
        begin
          st_nxt.cmd_state = CS_TXRX_TX;
          st_nxt.launch = 1'b0;
        end
      end
      CS_TXRX_TX:
        if (TX_DONE)
          st_nxt.cmd_state = CS_RX;
      CS_RX:
        if (RX_DONE)
          st_nxt.cmd_state = (st_r.cmd_code == `NFCPG_CMD_TXRX) ? CS_LAUNCH_WAIT : CS_IDLE;
      CS_AUTH:
        if (AUTH_DONE)
          st_nxt.cmd_state = CS_IDLE;
    endcase

    // host writes; a host set of the launch bit wins over the clear above
    if (REG_WR && REG_ADDR == `NFCPG_A_PRIVATE_PAGE_SELECTOR)
      st_nxt.page = REG_WDATA;
    if (REG_WR && REG_ADDR == `NFCPG_A_FRAMING)
      st_nxt.launch = REG_WDATA[`NFCPG_B_LAUNCH] | st_nxt.launch;
    if (wr_p4 && REG_ADDR == `NFCPG_A_SPECIAL)
      st_nxt.special = REG_WDATA;
    if (wr_p5)
    begin
      unique case (REG_ADDR)
        `NFCPG_A_ANALOG: st_nxt.analog = merge(st_r.analog, REG_WDATA, `NFCPG_M_ANALOG);
        `NFCPG_A_NOISE: st_nxt.noise = REG_WDATA;
        `NFCPG_A_STEP: st_nxt.step = merge(st_r.step, REG_WDATA, `NFCPG_M_STEP);
        `NFCPG_A_PAGE5_GAIN_THRESHOLD_A: st_nxt.page5_gain_threshold_a = merge(st_r.page5_gain_threshold_a, REG_WDATA, `NFCPG_M_PAGE5_GAIN_THRESHOLD_A);
        `NFCPG_A_ALG6: st_nxt.alg6 = REG_WDATA;
        `NFCPG_A_ALG7: st_nxt.alg7 = REG_WDATA;
        `NFCPG_A_ALG8: st_nxt.alg8 = REG_WDATA;
        `NFCPG_A_ALG9: st_nxt.alg9 = REG_WDATA;
        default: st_nxt.noise = st_nxt.noise;
      endcase
    end
    if (wr_p6)
    begin
      // detect reference and measured value are read-only
      unique case (REG_ADDR)
        `NFCPG_A_CAL: st_nxt.cal = REG_WDATA;
        `NFCPG_A_RC27: st_nxt.rc27 = REG_WDATA;
        `NFCPG_A_RC32: st_nxt.rc32 = merge(st_r.rc32, REG_WDATA, `NFCPG_M_RC32);
        `NFCPG_A_ADCREF: st_nxt.adcref = REG_WDATA;
        `NFCPG_A_CWGSN: st_nxt.cwgsn = merge(st_r.cwgsn, REG_WDATA, `NFCPG_M_CWGSN);
        `NFCPG_A_CWGSP: st_nxt.cwgsp = merge(st_r.cwgsp, REG_WDATA, `NFCPG_M_CWGSP);
        default: st_nxt.cal = st_nxt.cal;
      endcase
    end

    if (REG_WR && REG_ADDR == `NFCPG_A_COMMAND && REG_WDATA[3:0] != `NFCPG_CMD_KEEP)
    begin
      st_nxt.abort = (st_r.cmd_state != CS_IDLE);
      st_nxt.cmd_code = REG_WDATA[3:0];
      st_nxt.param_cnt = 4'h0;
      // FIFO left untouched; stream commands run at once
      unique case (REG_WDATA[3:0])
        `NFCPG_CMD_CRC: st_nxt.cmd_state = CS_STREAM;
        `NFCPG_CMD_TX: st_nxt.cmd_state = CS_TX;
        `NFCPG_CMD_RX: st_nxt.cmd_state = CS_RX;
        `NFCPG_CMD_TXRX: st_nxt.cmd_state = CS_LAUNCH_WAIT;
        `NFCPG_CMD_AUTH: st_nxt.cmd_state = CS_PARAMS;
        default: st_nxt.cmd_state = CS_IDLE;
      endcase
      // soft reset restores every register but keeps the host's selector
      if (REG_WDATA[3:0] == `NFCPG_CMD_SRST)
      begin
        st_nxt = rst_val;
        st_nxt.abort = (st_r.cmd_state != CS_IDLE);
        st_nxt.page = st_r.page;
        st_nxt.ref_s1 = DETECT_REF;
        st_nxt.det_s1 = DETECT_VAL;
        st_nxt.hot_s1 = TEMP_OVER;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      st_r <= rst_val;
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign REG_RDATA = st_r.rdata;
  assign TUNE = st_r.tune;
  assign CMD_ABORT = st_r.abort;
  assign PARAM_POP = (st_r.cmd_state == CS_PARAMS) && !FIFO_EMPTY;
  assign TX_EN = (st_r.cmd_state == CS_TX) || (st_r.cmd_state == CS_TXRX_TX);
  assign RX_EN = (st_r.cmd_state == CS_RX);
  assign CRC_EN = (st_r.cmd_state == CS_STREAM);
  assign AUTH_EN = (st_r.cmd_state == CS_AUTH);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  AST_P4_LOCK: assert property ((REG_WR && REG_ADDR == `NFCPG_A_SPECIAL && st_r.page != `NFCPG_UNLOCK_P4)
    |=> $stable(st_r.special)) else $error("page four written while locked");
  AST_P5_LOCK: assert property ((REG_WR && REG_ADDR == `NFCPG_A_ALG6 && st_r.page != `NFCPG_UNLOCK_P5
    && !(REG_ADDR == `NFCPG_A_COMMAND)) |=> $stable(st_r.alg6)) else $error("page five written while locked");
  AST_P6_LOCK: assert property ((REG_WR && REG_ADDR == `NFCPG_A_ADCREF && st_r.page == `NFCPG_UNLOCK_P6)
    |=> st_r.adcref == $past(REG_WDATA)) else $error("page six write lost");
  AST_RX_UNIT: assert property ($rose(st_r.special[`NFCPG_B_RXUNIT])
    |=> TUNE.rx_wait_unit == 8'h40) else $error("receive unit not 64");
  AST_TX_UNIT: assert property ($fell(st_r.special[`NFCPG_B_TXUNIT])
    |=> TUNE.tx_wait_unit == 8'h80) else $error("transmit unit not 128");
  AST_TEMP_OFF: assert property (st_r.analog[`NFCPG_B_TEMP_OFF] [*2] |-> !TUNE.tx_inhibit_hot)
    else $error("inhibit while protection off");
  AST_NO_EARLY_TX: assert property ((st_r.cmd_state == CS_LAUNCH_WAIT && !st_r.launch && !REG_WR)
    |=> !TX_EN) else $error("transceive sent before launch");
  AST_PARAMS_DONE: assert property ($rose(AUTH_EN) |-> $past(st_r.param_cnt) == 4'hB
    || $past(st_r.cmd_state) == CS_AUTH) else $error("auth began early");
  AST_ABORT: assert property ((REG_WR && REG_ADDR == `NFCPG_A_COMMAND && REG_WDATA[3:0] == `NFCPG_CMD_IDLE
    && st_r.cmd_state != CS_IDLE) |=> CMD_ABORT ##1 !CMD_ABORT) else $error("abort pulse missing");

endmodule : nfcpg_top

// [verilog/nfcpg_cfg.svh]
// constants of the paged tuning register bank and command sequencer
// assumes a byte-wide register port with a six-bit address, one clock
`ifndef NFCPG_CFG_SVH
`define NFCPG_CFG_SVH

// ****************************************
// page unlock values and addresses
// ****************************************
`define NFCPG_UNLOCK_P4 8'h5E
`define NFCPG_UNLOCK_P5 8'hAE
`define NFCPG_UNLOCK_P6 8'h5A
`define NFCPG_A_COMMAND 6'h01
`define NFCPG_A_FRAMING 6'h0D
`define NFCPG_A_PRIVATE_PAGE_SELECTOR 6'h37
`define NFCPG_A_SPECIAL 6'h3F
`define NFCPG_A_ANALOG 6'h31
`define NFCPG_A_NOISE 6'h32
`define NFCPG_A_STEP 6'h33
`define NFCPG_A_PAGE5_GAIN_THRESHOLD_A 6'h34
`define NFCPG_A_ALG6 6'h38
`define NFCPG_A_ALG7 6'h39
`define NFCPG_A_ALG8 6'h3A
`define NFCPG_A_ALG9 6'h3B
`define NFCPG_A_DREF 6'h31
`define NFCPG_A_DDET 6'h32
`define NFCPG_A_CAL 6'h33
`define NFCPG_A_RC27 6'h34
`define NFCPG_A_RC32 6'h35
`define NFCPG_A_ADCREF 6'h36
`define NFCPG_A_CWGSN 6'h38
`define NFCPG_A_CWGSP 6'h39

// ****************************************
// reset values and writable masks
// ****************************************
`define NFCPG_R_SPECIAL 8'h50
`define NFCPG_R_ANALOG 8'h14
`define NFCPG_R_NOISE 8'h7D
`define NFCPG_R_STEP 8'h00
`define NFCPG_R_PAGE5_GAIN_THRESHOLD_A 8'h10
`define NFCPG_R_ALG6 8'h76
`define NFCPG_R_ALG7 8'h56
`define NFCPG_R_ALG8 8'h31
`define NFCPG_R_ALG9 8'h12
`define NFCPG_R_CAL 8'h00
`define NFCPG_R_RC27 8'h80
`define NFCPG_R_RC32 8'h20
`define NFCPG_R_ADCREF 8'h80
`define NFCPG_R_CWGSN 8'h30
`define NFCPG_R_CWGSP 8'h1F
`define NFCPG_M_ANALOG 8'h3E
`define NFCPG_M_STEP 8'h0C
`define NFCPG_M_PAGE5_GAIN_THRESHOLD_A 8'h3F
`define NFCPG_M_RC32 8'h3F
`define NFCPG_M_CWGSN 8'hF0
`define NFCPG_M_CWGSP 8'h3F

// ****************************************
// field positions, commands, counts
// ****************************************
`define NFCPG_B_RXUNIT 1
`define NFCPG_B_TXUNIT 0
`define NFCPG_B_TEMP_OFF 5
`define NFCPG_B_RESYNC 4
`define NFCPG_B_FLT_BYP 7
`define NFCPG_B_SUBEND_OFF 3
`define NFCPG_B_CAL_METHOD 5
`define NFCPG_B_LAUNCH 7
`define NFCPG_UNIT_SLOW 8'h80
`define NFCPG_UNIT_FAST 8'h40
`define NFCPG_CMD_IDLE 4'h0
`define NFCPG_CMD_CRC 4'h3
`define NFCPG_CMD_TX 4'h4
`define NFCPG_CMD_KEEP 4'h7
`define NFCPG_CMD_RX 4'h8
`define NFCPG_CMD_TXRX 4'hC
`define NFCPG_CMD_AUTH 4'hE
`define NFCPG_CMD_SRST 4'hF
`define NFCPG_AUTH_PARAMS 4'hC

`endif

// [verilog/nfcpg_pkg.sv]
// types shared by the paged tuning register bank
// assumes nfcpg_cfg.svh is on the include path
`include "nfcpg_cfg.svh"
package nfcpg_pkg;

  typedef enum logic [2:0] {CS_IDLE, CS_PARAMS, CS_STREAM, CS_TX, CS_LAUNCH_WAIT, CS_TXRX_TX,
    CS_RX, CS_AUTH} nfcpg_cmd_state_t;

  typedef enum logic [1:0] {DEMOD_AUTO, DEMOD_ALG1, DEMOD_ALG2} nfcpg_demod_t;

  typedef struct packed {
    logic [7:0] rx_wait_unit;
    logic [7:0] tx_wait_unit;
    nfcpg_demod_t demod_algorithm_select;
    logic per_character_resync;
    logic top_rate_filter_bypass;
    logic subcarrier_end_check_off;
    logic tx_inhibit_hot;
    logic [5:0] search_lo;
    logic [5:0] search_hi;
  } nfcpg_tune_t;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] special;
    logic [7:0] analog;
    logic [7:0] noise;
    logic [7:0] step;
    logic [7:0] page5_gain_threshold_a;
    logic [7:0] alg6;
    logic [7:0] alg7;
    logic [7:0] alg8;
    logic [7:0] alg9;
    logic [7:0] cal;
    logic [7:0] rc27;
    logic [7:0] rc32;
    logic [7:0] adcref;
    logic [7:0] cwgsn;
    logic [7:0] cwgsp;
    logic [3:0] cmd_code;
    logic launch;
    nfcpg_cmd_state_t cmd_state;
    logic [3:0] param_cnt;
    logic abort;
    logic [7:0] rdata;
    logic [7:0] ref_s1;
    logic [7:0] ref_s2;
    logic [7:0] det_s1;
    logic [7:0] det_s2;
    logic [2:0] hot_s1;
    logic [2:0] hot_s2;
    nfcpg_tune_t tune;
  } nfcpg_state_t;

endpackage : nfcpg_pkg

// [test/nfcpg_dp_model.sv]
// FIFO and datapath model on the far side of the command sequencer
// assumes one clock with the design; LAT sets how slowly it answers
`timescale 1ns/100ps
module nfcpg_dp_model
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // bench control
  input wire logic PUSH,
  input wire logic [3:0] LAT,
  // design side
  input wire logic PARAM_POP,
  input wire logic TX_EN,
  input wire logic RX_EN,
  input wire logic AUTH_EN,
  output logic FIFO_EMPTY,
  output logic TX_DONE,
  output logic RX_DONE,
  output logic AUTH_DONE,
  output logic [4:0] POPS
);
  logic [4:0] level;
  logic [3:0] t;
  logic busy;
  logic hit;
  assign busy = TX_EN | RX_EN | AUTH_EN;
  assign hit = busy && (t == LAT);
  assign FIFO_EMPTY = (level == 5'h00);
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      level <= 5'h00;
      POPS <= 5'h00;
      t <= 4'h0;
      TX_DONE <= 1'b0;
      RX_DONE <= 1'b0;
      AUTH_DONE <= 1'b0;
    end
    else
    begin
      // pops only while not empty; a push in the same cycle still counts
      level <= level + 5'(PUSH) - 5'(PARAM_POP && level != 5'h00);
      if (PARAM_POP && level != 5'h00)
        POPS <= POPS + 5'h01;
      t <= (busy && !hit) ? t + 4'h1 : 4'h0;
      TX_DONE <= hit & TX_EN;
      RX_DONE <= hit & RX_EN;
      AUTH_DONE <= hit & AUTH_EN;
    end
  end
endmodule : nfcpg_dp_model

// [test/tb.sv]
// self-checking bench for the paged tuning register bank
// assumes nfcpg_dp_model stands in for the FIFO and datapath
`timescale 1ns/100ps
module tb
  import nfcpg_pkg::*;
;
  logic clk, rst, wr, rd, push, fe, txd, rxd, aud, pop, abt, txe, rxe, crce, aue;
  logic [5:0] addr;
  logic [7:0] wd, rdat, dref, dval;
  logic [2:0] hot;
  logic [3:0] lat;
  logic [4:0] pops;
  nfcpg_tune_t tune;
  int n_errors, tests_run, i;
  logic [5:0] a5 [8] = '{6'h31, 6'h32, 6'h33, 6'h34, 6'h38, 6'h39, 6'h3A, 6'h3B};
  logic [7:0] r5 [8] = '{8'h14, 8'h7D, 8'h00, 8'h10, 8'h76, 8'h56, 8'h31, 8'h12};
  logic [7:0] m5 [8] = '{8'h3E, 8'hFF, 8'h0C, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [5:0] a6 [6] = '{6'h33, 6'h34, 6'h35, 6'h36, 6'h38, 6'h39};
  logic [7:0] r6 [6] = '{8'h00, 8'h80, 8'h20, 8'h80, 8'h30, 8'h1F};
  logic [7:0] m6 [6] = '{8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hF0, 8'h3F};
  logic [7:0] lo [4] = '{8'h17, 8'h0F, 8'h07, 8'h02};
  logic [7:0] hi [4] = '{8'h26, 8'h2D, 8'h34, 8'h3E};

  nfcpg_top nfcpg_top_inst (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdat), .FIFO_EMPTY(fe), .TX_DONE(txd), .RX_DONE(rxd), .AUTH_DONE(aud),
    .PARAM_POP(pop), .CMD_ABORT(abt), .TX_EN(txe), .RX_EN(rxe), .CRC_EN(crce), .AUTH_EN(aue),
    .DETECT_REF(dref), .DETECT_VAL(dval), .TEMP_OVER(hot), .TUNE(tune));
  nfcpg_dp_model nfcpg_dp_model_inst (.CLK(clk), .RST(rst), .PUSH(push), .LAT(lat), .PARAM_POP(pop),
    .TX_EN(txe), .RX_EN(rxe), .AUTH_EN(aue), .FIFO_EMPTY(fe), .TX_DONE(txd), .RX_DONE(rxd),
    .AUTH_DONE(aud), .POPS(pops));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // access and compare tasks
  // ****************************************
  task final_report;
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task wrr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr

  task rdr(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask : rdr

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task psh(input int n);
    repeat (n)
    begin
      @(posedge clk);
      push <= 1'b1;
    end
    @(posedge clk);
    push <= 1'b0;
  endtask : psh

  function automatic logic cnd(input int k);
    case (k)
      0: cnd = txe;
      1: cnd = rxe;
      2: cnd = aue;
      3: cnd = abt;
      4: cnd = tune.tx_inhibit_hot;
      6: cnd = crce;
      default: cnd = !txe && !rxe && !aue;
    endcase
  endfunction : cnd

  // polls every cycle, so a one-cycle pulse is not missed
  task wt(input int k);
    int c;
    c = 0;
    #1;
    while (cnd(k) !== 1'b1)
    begin
      @(posedge clk);
      #1;
      c++;
      if (c > 200)
      begin
        n_errors++;
        $display("wrong value at %0t: wait %0d timed out", $time, k);
        final_report();
      end
    end
  endtask : wt

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    n_errors = 0;
    tests_run = 0;
    {wr, rd, push, addr, wd} = '0;
    rst = 1'b1;
    lat = 4'h3;
    dref = 8'h5C;
    dval = 8'hA3;
    hot = 3'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    tick(3);
    chk(tune.rx_wait_unit, 8'h80);
    chk(tune.tx_wait_unit, 8'h80);
    chk(tune.top_rate_filter_bypass, 8'h00);
    chk(tune.subcarrier_end_check_off, 8'h00);
    chk(tune.per_character_resync, 8'h01);
    rdr(6'h38, 8'h00);
    wrr(6'h37, 8'h5E);
    rdr(6'h3F, 8'h50);
    rdr(6'h38, 8'h00);
    wrr(6'h3F, 8'h23);
    tick(2);
    chk(tune.rx_wait_unit, 8'h40);
    chk(tune.tx_wait_unit, 8'h40);
    chk(tune.demod_algorithm_select, DEMOD_ALG2);
    wrr(6'h3F, 8'h12);
    tick(2);
    chk(tune.rx_wait_unit, 8'h40);
    chk(tune.tx_wait_unit, 8'h80);
    chk(tune.demod_algorithm_select, DEMOD_ALG1);
    wrr(6'h3F, 8'h30);
    tick(2);
    chk(tune.demod_algorithm_select, DEMOD_AUTO);
    wrr(6'h37, 8'hAE);
    for (i = 0; i < 8; i++) rdr(a5[i], r5[i]);
    for (i = 0; i < 8; i++) wrr(a5[i], 8'hFF);
    for (i = 0; i < 8; i++) rdr(a5[i], m5[i]);
    tick(2);
    chk(tune.top_rate_filter_bypass, 8'h01);
    chk(tune.subcarrier_end_check_off, 8'h01);
    chk(tune.per_character_resync, 8'h01);
    hot <= 3'b011;
    for (i = 0; i < 4; i++)
    begin
      wrr(6'h31, {3'b000, i[1:0], 3'b000});
      tick(6);
      chk(tune.tx_inhibit_hot, 8'(i == 1 || i == 2));
    end
    wrr(6'h31, 8'h28);
    tick(6);
    chk(tune.tx_inhibit_hot, 8'h00);
    wrr(6'h37, 8'h5A);
    rdr(6'h31, 8'h5C);
    rdr(6'h32, 8'hA3);
    wrr(6'h31, 8'hFF);
    rdr(6'h31, 8'h5C);
    for (i = 0; i < 6; i++) rdr(a6[i], r6[i]);
    for (i = 0; i < 6; i++) wrr(a6[i], 8'hFF);
    for (i = 0; i < 6; i++) rdr(a6[i], m6[i]);
    wrr(6'h39, 8'h1F);
    for (i = 0; i < 4; i++)
    begin
      wrr(6'h33, {i[1:0], 6'h20});
      tick(2);
      chk(tune.search_lo, lo[i]);
      chk(tune.search_hi, hi[i]);
    end
    wrr(6'h01, 8'h03);
    wt(6);
    wrr(6'h01, 8'h07);
    tick(2);
    chk(crce, 8'h01);
    rdr(6'h01, 8'h03);
    wrr(6'h01, 8'h00);
    wt(3);
    chk(crce, 8'h00);
    wrr(6'h01, 8'h04);
    wt(0);
    wt(5);
    wrr(6'h01, 8'h08);
    wt(1);
    wt(5);
    lat <= 4'h9;
    wrr(6'h01, 8'h0C);
    tick(4);
    chk(txe, 8'h00);
    wrr(6'h0D, 8'h80);
    wt(0);
    wt(1);
    wt(5);
    tick(3);
    chk(txe, 8'h00);
    wrr(6'h0D, 8'h80);
    wt(1);
    wrr(6'h01, 8'h00);
    wt(3);
    chk(rxe, 8'h00);
    lat <= 4'h3;
    psh(11);
    wrr(6'h01, 8'h0E);
    tick(20);
    chk(aue, 8'h00);
    chk(pops, 8'h0B);
    psh(1);
    wt(2);
    chk(pops, 8'h0C);
    wt(5);
    wrr(6'h01, 8'h0F);
    rdr(6'h33, 8'h00);
    rdr(6'h37, 8'h5A);
    rdr(6'h01, 8'h00);
    final_report();
  end
endmodule : tb
